// >>> baud_div.v
// divider that makes one 16x baud clock from reference edge ticks
`timescale 1ns/1ps

module baud_div #(
    parameter DIV_W = 13
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_resetn,
    // reference edge tick and divisor
    input  wire             i_edge,
    input  wire [DIV_W-1:0] i_divisor,
    // divided clock
    output wire             o_clk
);

    reg  [DIV_W-1:0] cnt_q;
    reg              clk_q;

    // ***********************************************************************
    // half period counter
    // ***********************************************************************
    // both reference edges are counted, so toggling every divisor edges gives
    // an exact half period even for odd divisors and for a divisor of one
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            cnt_q <= {DIV_W{1'b0}};
            clk_q <= 1'b0;
        end else if (i_edge) begin
            // >= so a smaller divisor written mid count cannot run away
            if (cnt_q >= i_divisor - {{(DIV_W-1){1'b0}}, 1'b1}) begin
                cnt_q <= {DIV_W{1'b0}};
                clk_q <= ~clk_q;
            end else begin
                cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign o_clk = clk_q;

endmodule // baud_div

// >>> duart_baud_clock_select.v
// per channel receiver and transmitter baud clock selection with command register decode
//
// Overview of operation
// - clock select bits 7..4 pick receiver clock, bits 3..0 transmitter clock.
// - channel A receiver: 1110 fourth pin 16x, 1111 same pin 1x.
// - channel A transmitter: 1110 third pin 16x, 1111 same pin 1x.
// - channel B receiver: 1110 sixth pin 16x, 1111 same pin 1x.
// - channel B transmitter: 1110 fifth pin 16x, 1111 same pin 1x.
// - codes 0000..1100 fixed rates by mode and rate set; 1101 picks timer.
// - generator makes tabulated 16x clocks from the 3.6864 MHz reference.
// - generated 16x clock has 50 percent duty cycle.
// - clock select registers decode at 0x1 and 0x9.
// - command registers 0x2 and 0xA: code nibble, then Tx/Rx disable/enable bits.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "duart_clk_regs.vh"

module duart_baud_clock_select (
    // clock and reset
    input  wire       i_clk,
    input  wire       i_resetn,
    // register port
    input  wire [4:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output wire [7:0] o_rdata,
    // clock sources
    input  wire       i_xtal,
    input  wire       i_timer_clk,
    input  wire       i_ext_in_three,
    input  wire       i_ext_in_four,
    input  wire       i_ext_in_five,
    input  wire       i_ext_in_six,
    // selected baud clocks and 1x flags
    output wire       o_rx_clk_a,
    output wire       o_tx_clk_a,
    output wire       o_rx_clk_b,
    output wire       o_tx_clk_b,
    output wire       o_rx_x1_a,
    output wire       o_tx_x1_a,
    output wire       o_rx_x1_b,
    output wire       o_tx_x1_b,
    // channel commands
    output wire [3:0] o_cmd_code_a,
    output wire       o_cmd_strobe_a,
    output wire [3:0] o_cmd_code_b,
    output wire       o_cmd_strobe_b,
    output wire       o_rx_en_a,
    output wire       o_tx_en_a,
    output wire       o_rx_en_b,
    output wire       o_tx_en_b
);

    // path index: 0 receiver A, 1 transmitter A, 2 receiver B, 3 transmitter B
    localparam NPATH = 4;

    // ****************************************
    // divisor lookup
    // ****************************************
    // extended mode II wins when both mode bits are set
    function [`DIV_W-1:0] rate_div;
        input [3:0] code;
        input       ext_one;
        input       ext_two;
        input       rate_set;
        begin
            rate_div = `DIV_230400;
            if (ext_two) begin
                case (code)
                    4'h0:    rate_div = rate_set ? `DIV_7200  : `DIV_4800;
                    4'h1:    rate_div = `DIV_880;
                    4'h2:    rate_div = `DIV_1076;
                    4'h3:    rate_div = rate_set ? `DIV_14400 : `DIV_19200;
                    4'h4:    rate_div = `DIV_28800;
                    4'h5:    rate_div = `DIV_57600;
                    4'h6:    rate_div = `DIV_115200;
                    4'h7:    rate_div = rate_set ? `DIV_2000  : `DIV_1050;
                    4'h8:    rate_div = `DIV_57600;
                    4'h9:    rate_div = `DIV_4800;
                    4'hA:    rate_div = rate_set ? `DIV_14400 : `DIV_57600;
                    4'hB:    rate_div = `DIV_9600;
                    4'hC:    rate_div = rate_set ? `DIV_19200 : `DIV_38400;
                    default: rate_div = `DIV_230400;
                endcase
            end else if (ext_one) begin
                case (code)
                    4'h0:    rate_div = rate_set ? `DIV_450    : `DIV_300;
                    4'h1:    rate_div = `DIV_110;
                    4'h2:    rate_div = `DIV_134;
                    4'h3:    rate_div = rate_set ? `DIV_900    : `DIV_1200;
                    4'h4:    rate_div = `DIV_1800;
                    4'h5:    rate_div = `DIV_3600;
                    4'h6:    rate_div = `DIV_7200;
                    4'h7:    rate_div = rate_set ? `DIV_2000   : `DIV_1050;
                    4'h8:    rate_div = `DIV_14400;
                    4'h9:    rate_div = `DIV_28800;
                    4'hA:    rate_div = rate_set ? `DIV_1800   : `DIV_7200;
                    4'hB:    rate_div = `DIV_57600;
                    4'hC:    rate_div = rate_set ? `DIV_115200 : `DIV_230400;
                    default: rate_div = `DIV_230400;
                endcase
            end else begin
                case (code)
                    4'h0:    rate_div = rate_set ? `DIV_75    : `DIV_50;
                    4'h1:    rate_div = `DIV_110;
                    4'h2:    rate_div = `DIV_134;
                    4'h3:    rate_div = rate_set ? `DIV_150   : `DIV_200;
                    4'h4:    rate_div = `DIV_300;
                    4'h5:    rate_div = `DIV_600;
                    4'h6:    rate_div = `DIV_1200;
                    4'h7:    rate_div = rate_set ? `DIV_2000  : `DIV_1050;
                    4'h8:    rate_div = `DIV_2400;
                    4'h9:    rate_div = `DIV_4800;
                    4'hA:    rate_div = rate_set ? `DIV_1800  : `DIV_7200;
                    4'hB:    rate_div = `DIV_9600;
                    4'hC:    rate_div = rate_set ? `DIV_19200 : `DIV_38400;
                    default: rate_div = `DIV_230400;
                endcase
            end
        end
    endfunction

    // ****************************************
    // registers
    // ****************************************
    reg  [7:0]       csel_a_q;
    reg  [7:0]       csel_b_q;
    reg  [7:0]       rate_ctl_q;
    reg  [7:0]       rdata_q;
    reg  [3:0]       code_a_q;
    reg  [3:0]       code_b_q;
    reg              strobe_a_q;
    reg              strobe_b_q;
    reg              rx_en_a_q;
    reg              tx_en_a_q;
    reg              rx_en_b_q;
    reg              tx_en_b_q;
    reg  [1:0]       xtal_sync_q;
    reg              xtal_prev_q;
    reg  [NPATH-1:0] pin_meta_q;
    reg  [NPATH-1:0] pin_sync_q;
    reg  [NPATH-1:0] clk_q;
    reg  [NPATH-1:0] x1_q;

    wire             wr_cmd_a;
    wire             wr_cmd_b;
    wire             xtal_edge;
    wire [NPATH-1:0] pin_raw;
    wire [NPATH-1:0] gen_clk;
    wire [15:0]      codes;

    // ****************************************
    // register writes
    // ****************************************
    assign wr_cmd_a = i_wr && (i_addr == `OFS_CHAN_A_COMMAND);
    assign wr_cmd_b = i_wr && (i_addr == `OFS_CHAN_B_COMMAND);

    // clock select and rate control storage
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            csel_a_q   <= `RST_CLK_SEL;
            csel_b_q   <= `RST_CLK_SEL;
            rate_ctl_q <= `RST_RATE_CONTROL;
        end else if (i_wr) begin
            if (i_addr == `OFS_CHAN_A_CLK_SEL) begin
                csel_a_q <= i_wdata;
            end
            if (i_addr == `OFS_CHAN_B_CLK_SEL) begin
                csel_b_q <= i_wdata;
            end
            if (i_addr == `OFS_RATE_CONTROL) begin
                rate_ctl_q <= i_wdata;
            end
        end
    end

    // command decode: code nibble is passed on as a one cycle strobe
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            code_a_q   <= 4'h0;
            code_b_q   <= 4'h0;
            strobe_a_q <= 1'b0;
            strobe_b_q <= 1'b0;
        end else begin
            strobe_a_q <= wr_cmd_a;
            strobe_b_q <= wr_cmd_b;
            if (wr_cmd_a) begin
                code_a_q <= i_wdata[`CMD_CODE_HI:`CMD_CODE_LO];
            end
            if (wr_cmd_b) begin
                code_b_q <= i_wdata[`CMD_CODE_HI:`CMD_CODE_LO];
            end
        end
    end

    // enable state: a disable in the same word as its enable wins, the safe side
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            rx_en_a_q <= 1'b0;
            tx_en_a_q <= 1'b0;
            rx_en_b_q <= 1'b0;
            tx_en_b_q <= 1'b0;
        end else begin
            if (wr_cmd_a) begin
                if (i_wdata[`CMD_TX_DISABLE]) begin
                    tx_en_a_q <= 1'b0;
                end else if (i_wdata[`CMD_TX_ENABLE]) begin
                    tx_en_a_q <= 1'b1;
                end
                if (i_wdata[`CMD_RX_DISABLE]) begin
                    rx_en_a_q <= 1'b0;
                end else if (i_wdata[`CMD_RX_ENABLE]) begin
                    rx_en_a_q <= 1'b1;
                end
            end
            if (wr_cmd_b) begin
                if (i_wdata[`CMD_TX_DISABLE]) begin
                    tx_en_b_q <= 1'b0;
                end else if (i_wdata[`CMD_TX_ENABLE]) begin
                    tx_en_b_q <= 1'b1;
                end
                if (i_wdata[`CMD_RX_DISABLE]) begin
                    rx_en_b_q <= 1'b0;
                end else if (i_wdata[`CMD_RX_ENABLE]) begin
                    rx_en_b_q <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    // select and command registers are write only and read as zero
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            rdata_q <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `OFS_RATE_CONTROL: rdata_q <= rate_ctl_q;
                `OFS_CLOCK_STATUS: rdata_q <= {tx_en_b_q, rx_en_b_q, tx_en_a_q, rx_en_a_q, x1_q};
                default:           rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    assign pin_raw = {i_ext_in_five, i_ext_in_six, i_ext_in_three, i_ext_in_four};

    // reference edges are only looked at past the second stage
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            xtal_sync_q <= 2'b00;
            xtal_prev_q <= 1'b0;
            pin_meta_q  <= {NPATH{1'b0}};
            pin_sync_q  <= {NPATH{1'b0}};
        end else begin
            xtal_sync_q <= {xtal_sync_q[0], i_xtal};
            xtal_prev_q <= xtal_sync_q[1];
            pin_meta_q  <= pin_raw;
            pin_sync_q  <= pin_meta_q;
        end
    end

    // both reference edges; the reference must stay well below half of i_clk
    assign xtal_edge = xtal_sync_q[1] ^ xtal_prev_q;

    // ****************************************
    // generator and selection per path
    // ****************************************
    // code nibbles: receiver from bits 7..4, transmitter from bits 3..0
    assign codes = {csel_b_q[`CSEL_TX_HI:`CSEL_TX_LO], csel_b_q[`CSEL_RX_HI:`CSEL_RX_LO],
                    csel_a_q[`CSEL_TX_HI:`CSEL_TX_LO], csel_a_q[`CSEL_RX_HI:`CSEL_RX_LO]};

    genvar gi;
    generate
        for (gi = 0; gi < NPATH; gi = gi + 1) begin : g_path
            wire [3:0] code = codes[4*gi+3:4*gi];

            // one divider per path so every direction may run its own rate
            baud_div #(
                .DIV_W (`DIV_W)
            ) u_div (
                .i_clk     (i_clk),
                .i_resetn  (i_resetn),
                .i_edge    (xtal_edge),
                .i_divisor (rate_div(code, rate_ctl_q[`RC_EXT_MODE_ONE],
                                     rate_ctl_q[`RC_EXT_MODE_TWO], rate_ctl_q[`RC_RATE_SET])),
                .o_clk     (gen_clk[gi])
            );

            // clock mux; pins feed receiver A four, transmitter A three, receiver B six, transmitter B five
            always @(posedge i_clk) begin
                if (!i_resetn) begin
                    clk_q[gi] <= 1'b0;
                    x1_q[gi]  <= 1'b0;
                end else begin
                    case (code)
                        `CODE_TIMER: begin
                            clk_q[gi] <= i_timer_clk;
                            x1_q[gi]  <= 1'b0;
                        end
                        `CODE_PIN_X16: begin
                            clk_q[gi] <= pin_sync_q[gi];
                            x1_q[gi]  <= 1'b0;
                        end
                        `CODE_PIN_X1: begin
                            clk_q[gi] <= pin_sync_q[gi];
                            x1_q[gi]  <= 1'b1;
                        end
                        default: begin
                            clk_q[gi] <= gen_clk[gi];
                            x1_q[gi]  <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ****************************************
    // outputs
    // ****************************************
    assign o_rdata        = rdata_q;
    assign o_rx_clk_a     = clk_q[0];
    assign o_tx_clk_a     = clk_q[1];
    assign o_rx_clk_b     = clk_q[2];
    assign o_tx_clk_b     = clk_q[3];
    assign o_rx_x1_a      = x1_q[0];
    assign o_tx_x1_a      = x1_q[1];
    assign o_rx_x1_b      = x1_q[2];
    assign o_tx_x1_b      = x1_q[3];
    assign o_cmd_code_a   = code_a_q;
    assign o_cmd_strobe_a = strobe_a_q;
    assign o_cmd_code_b   = code_b_q;
    assign o_cmd_strobe_b = strobe_b_q;
    assign o_rx_en_a      = rx_en_a_q;
    assign o_tx_en_a      = tx_en_a_q;
    assign o_rx_en_b      = rx_en_b_q;
    assign o_tx_en_b      = tx_en_b_q;

endmodule // duart_baud_clock_select

// >>> duart_baud_clock_select_properties.sv
// port level assertions of the baud clock select block
`timescale 1ns/1ps
`include "duart_clk_regs.vh"

module duart_baud_clock_select_checker (
    // clock and reset
    input wire       i_clk,
    input wire       i_resetn,
    // register port
    input wire [4:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    // clock paths
    input wire       i_ext_in_four,
    input wire       o_rx_clk_a,
    input wire       o_rx_x1_a,
    input wire       o_tx_x1_a,
    input wire       o_rx_x1_b,
    // commands
    input wire [3:0] o_cmd_code_b,
    input wire       o_cmd_strobe_a,
    input wire       o_cmd_strobe_b,
    input wire       o_rx_en_a,
    input wire       o_tx_en_b
);
    // ***********************************************************
    // decoded writes and properties
    // ***********************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    wire wr_a  = i_wr && i_addr == `OFS_CHAN_A_COMMAND;
    wire wr_b  = i_wr && i_addr == `OFS_CHAN_B_COMMAND;
    wire sel_a = i_wr && i_addr == `OFS_CHAN_A_CLK_SEL;
    wire sel_b = i_wr && i_addr == `OFS_CHAN_B_CLK_SEL;
    wire tx1_a = i_wdata[3:0] == `CODE_PIN_X1;
    wire rx1_b = i_wdata[7:4] == `CODE_PIN_X1;

    chk_strobe_a_fires: assert property (wr_a |=> o_cmd_strobe_a)
        else $error("command strobe a missing");
    chk_strobe_b_cause: assert property (o_cmd_strobe_b |-> $past(wr_b))
        else $error("command strobe b without write");
    chk_code_b_taken: assert property (wr_b |=> o_cmd_code_b == $past(i_wdata[7:4]))
        else $error("command code b wrong");
    chk_rx_dis_a: assert property (wr_a && i_wdata[1] |=> !o_rx_en_a)
        else $error("receiver a not disabled");
    chk_tx_en_b: assert property (wr_b && i_wdata[3:2] == 2'b01 |=> o_tx_en_b)
        else $error("transmitter b not enabled");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_csel_write_only: assert property (i_rd && i_addr == `OFS_CHAN_A_CLK_SEL |=> o_rdata == 8'h00)
        else $error("clock select read not zero");
    chk_x1_tx_a: assert property (sel_a |-> ##3 o_tx_x1_a == $past(tx1_a, 3))
        else $error("tx a 1x flag wrong");
    chk_x1_rx_b: assert property (sel_b |-> ##3 o_rx_x1_b == $past(rx1_b, 3))
        else $error("rx b 1x flag wrong");
    chk_pin_rx_a: assert property ((o_rx_x1_a && $stable(i_ext_in_four)) [*4] |-> o_rx_clk_a == i_ext_in_four)
        else $error("rx a not following pin");

    cover property (wr_a ##1 o_cmd_strobe_a);
    cover property (o_rx_x1_a && o_tx_x1_a == 1'b0);
    cover property ($past(i_rd) && o_rdata != 8'h00);
endmodule // duart_baud_clock_select_checker

bind duart_baud_clock_select duart_baud_clock_select_checker chk (.*);

// >>> duart_clk_regs.vh
// register offsets, fields, reset values and divisor counts of the baud clock select block
`ifndef DUART_CLK_REGS_VH
`define DUART_CLK_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_W                5
`define OFS_CHAN_A_CLK_SEL    5'h01
`define OFS_CHAN_A_COMMAND    5'h02
`define OFS_CHAN_B_CLK_SEL    5'h09
`define OFS_CHAN_B_COMMAND    5'h0A
`define OFS_RATE_CONTROL      5'h10
`define OFS_CLOCK_STATUS      5'h11

// ****************************************
// field positions
// ****************************************
`define CSEL_RX_HI            7
`define CSEL_RX_LO            4
`define CSEL_TX_HI            3
`define CSEL_TX_LO            0
`define CMD_CODE_HI           7
`define CMD_CODE_LO           4
`define CMD_TX_DISABLE        3
`define CMD_TX_ENABLE         2
`define CMD_RX_DISABLE        1
`define CMD_RX_ENABLE         0
`define RC_EXT_MODE_ONE       0
`define RC_EXT_MODE_TWO       2
`define RC_RATE_SET           7

// ****************************************
// clock select codes
// ****************************************
`define CODE_TIMER            4'hD
`define CODE_PIN_X16          4'hE
`define CODE_PIN_X1           4'hF

// ****************************************
// reset values
// ****************************************
`define RST_CLK_SEL           8'h00
`define RST_RATE_CONTROL      8'h00

// ****************************************
// reference and divisors: reference / (16 * baud), counted on both reference edges
// ****************************************
`define DIV_W                 13
`define DIV_50                13'h1200
`define DIV_75                13'h0C00
`define DIV_110               13'h0830
`define DIV_134               13'h06B0
`define DIV_150               13'h0600
`define DIV_200               13'h0480
`define DIV_300               13'h0300
`define DIV_450               13'h0200
`define DIV_600               13'h0180
`define DIV_880               13'h0106
`define DIV_900               13'h0100
`define DIV_1050              13'h00DC
`define DIV_1076              13'h00D6
`define DIV_1200              13'h00C0
`define DIV_1800              13'h0080
`define DIV_2000              13'h0073
`define DIV_2400              13'h0060
`define DIV_3600              13'h0040
`define DIV_4800              13'h0030
`define DIV_7200              13'h0020
`define DIV_9600              13'h0018
`define DIV_14400             13'h0010
`define DIV_19200             13'h000C
`define DIV_28800             13'h0008
`define DIV_38400             13'h0006
`define DIV_57600             13'h0004
`define DIV_115200            13'h0002
`define DIV_230400            13'h0001

`endif

// >>> host_bus_model.sv
// host side register master of the baud clock select block
`timescale 1ns/1ps

module host_bus_model (
    // clock
    input  wire       i_clk,
    // register port
    input  wire [7:0] i_rdata,
    output reg  [4:0] o_addr,
    output reg  [7:0] o_wdata,
    output reg        o_wr,
    output reg        o_rd
);
    // ***********************************************************
    // bus cycles
    // ***********************************************************
    // bus idle from time zero
    initial begin
        o_addr = 5'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // one cycle write, the slave never stalls
    task wr_reg(input [4:0] a, input [7:0] d);
        begin
            @(posedge i_clk);
            o_addr <= a;
            o_wdata <= d;
            o_wr <= 1'b1;
            @(posedge i_clk);
            o_wr <= 1'b0;
        end
    endtask

    // data only valid in the cycle after the strobe
    task rd_reg(input [4:0] a, output [7:0] d);
        begin
            @(posedge i_clk);
            o_addr <= a;
            o_rd <= 1'b1;
            @(posedge i_clk);
            o_rd <= 1'b0;
            #1 d = i_rdata;
        end
    endtask
endmodule // host_bus_model

// >>> test_duart_baud_clock_select.sv
// self-checking testbench of the baud clock select block
`timescale 1ns/1ps
`include "duart_clk_regs.vh"

module test_duart_baud_clock_select;
    // ***********************************************************
    // stimulus, checks and scenarios
    // ***********************************************************
    reg        clk = 1'b0;
    reg        resetn = 1'b0;
    reg        xtal = 1'b0;
    reg        tmr = 1'b0;
    reg  [3:0] pins = 4'h0;      // {six, five, four, three}
    wire [4:0] addr;
    wire [7:0] wdata;
    wire [7:0] rdata;
    wire       wr;
    wire       rd;
    wire [3:0] clks;             // {tx b, rx b, tx a, rx a}
    wire [3:0] x1s;              // same order
    wire [3:0] ens;              // same order
    wire [3:0] cmd_a;
    wire [3:0] cmd_b;
    wire       stb_a;
    wire       stb_b;
    integer    fails = 0;
    integer    cmp_count = 0;
    integer    i;
    integer    k;
    reg  [7:0] d;
    reg  [7:0] rv;
    reg  [3:0] en_exp;
    real       t0, t1, t2;

    always #12.5 clk = ~clk;
    // reference free running, phase unrelated to clk
    always #135.634 xtal = ~xtal;

    host_bus_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    duart_baud_clock_select uut (
        .i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_xtal(xtal), .i_timer_clk(tmr), .i_ext_in_three(pins[0]),
        .i_ext_in_four(pins[1]), .i_ext_in_five(pins[2]), .i_ext_in_six(pins[3]),
        .o_rx_clk_a(clks[0]), .o_tx_clk_a(clks[1]), .o_rx_clk_b(clks[2]), .o_tx_clk_b(clks[3]),
        .o_rx_x1_a(x1s[0]), .o_tx_x1_a(x1s[1]), .o_rx_x1_b(x1s[2]), .o_tx_x1_b(x1s[3]),
        .o_cmd_code_a(cmd_a), .o_cmd_strobe_a(stb_a), .o_cmd_code_b(cmd_b), .o_cmd_strobe_b(stb_b),
        .o_rx_en_a(ens[0]), .o_tx_en_a(ens[1]), .o_rx_en_b(ens[2]), .o_tx_en_b(ens[3]));

    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
            end
        end
    endtask

    task wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, fails);
            if (fails == 0 && cmp_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // disable beats enable when both are set
    function en_next(input prev, input en, input dis);
        en_next = dis ? 1'b0 : (en ? 1'b1 : prev);
    endfunction

    // bounded wait for a level on one clock path
    task wait_lvl(input [1:0] s, input v);
        integer n;
        begin
            n = 0;
            while (clks[s] !== v && n < 12000) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n == 12000) begin
                fails = fails + 1;
                wrap_up;
            end
        end
    endtask

    // skip periods after a divisor change; allow sampling jitter plus rounded divisor error
    task measure(input [1:0] s, input real baud);
        real per;
        real tol;
        begin
            per = 1.0e9 / (16.0 * baud);
            tol = 60.0 + per / 400.0;
            wait_lvl(s, 1'b0);
            wait_lvl(s, 1'b1);
            wait_lvl(s, 1'b0);
            wait_lvl(s, 1'b1);
            t0 = $realtime;
            wait_lvl(s, 1'b0);
            t1 = $realtime;
            wait_lvl(s, 1'b1);
            t2 = $realtime;
            check("period", (t2 - t0 - per) ** 2 < tol * tol, 32'd1);
            check("duty", (t1 - t0 - per / 2.0) ** 2 < tol * tol, 32'd1);
        end
    endtask

    task gen_case(input [7:0] rc, input [3:0] c, input real baud);
        begin
            host.wr_reg(`OFS_RATE_CONTROL, rc);
            host.wr_reg(`OFS_CHAN_A_CLK_SEL, {c, c});
            host.wr_reg(`OFS_CHAN_B_CLK_SEL, {c, c});
            measure(2'($urandom), baud);
        end
    endtask

    initial begin
        rv = 8'($urandom(32'h3242));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        // reset state and register map, unmapped write ignored
        host.rd_reg(`OFS_CLOCK_STATUS, d);
        check("status", d, 8'h00);
        rv = 8'($urandom);
        host.wr_reg(`OFS_RATE_CONTROL, rv);
        host.wr_reg(5'h03, ~rv);
        host.rd_reg(`OFS_RATE_CONTROL, d);
        check("rate", d, rv);
        host.rd_reg(`OFS_CHAN_B_CLK_SEL, d);
        check("csel read", d, 8'h00);
        host.wr_reg(`OFS_RATE_CONTROL, 8'h00);
        $display("end test registers");
        // every command code on both channels, first pair sets both enable and disable
        en_exp = 4'h0;
        for (i = 0; i < 32; i = i + 1) begin
            d = {i[4:1], (i < 2) ? 4'hF : 4'($urandom)};
            host.wr_reg(i[0] ? `OFS_CHAN_B_COMMAND : `OFS_CHAN_A_COMMAND, d);
            k = i[0] * 2;
            en_exp[k] = en_next(en_exp[k], d[0], d[1]);
            en_exp[k+1] = en_next(en_exp[k+1], d[2], d[3]);
            #1;
            check("strobe", {stb_b, stb_a}, i[0] ? 2'b10 : 2'b01);
            check("code", i[0] ? cmd_b : cmd_a, d[7:4]);
            check("enables", ens, en_exp);
        end
        host.rd_reg(`OFS_CLOCK_STATUS, d);
        check("status en", d[7:4], en_exp);
        $display("end test commands");
        // pin clocks, 16x and 1x on each path
        for (i = 0; i < 4; i = i + 1) begin
            host.wr_reg(`OFS_CHAN_A_CLK_SEL, i[0] ? 8'hEF : 8'hFE);
            host.wr_reg(`OFS_CHAN_B_CLK_SEL, i[1] ? 8'hEF : 8'hFE);
            for (k = 0; k < 6; k = k + 1) begin
                @(posedge clk);
                pins <= 4'($urandom);
                repeat (5) @(posedge clk);
                #1;
                check("pin clk", clks, {pins[2], pins[3], pins[0], pins[1]});
            end
            host.rd_reg(`OFS_CLOCK_STATUS, d);
            check("x1", {x1s, d[3:0]}, {2{i[1], ~i[1], i[0], ~i[0]}});
        end
        // timer code on all paths
        host.wr_reg(`OFS_CHAN_A_CLK_SEL, 8'hDD);
        host.wr_reg(`OFS_CHAN_B_CLK_SEL, 8'hDD);
        for (k = 0; k < 6; k = k + 1) begin
            @(posedge clk);
            tmr <= 1'($urandom);
            repeat (3) @(posedge clk);
            #1;
            check("timer", clks, {4{tmr}});
        end
        $display("end test clock sources");
        // generator across modes and rate sets, mode II wins over mode I
        gen_case(8'h00, 4'hB, 9600.0);
        gen_case(8'h04, 4'h1, 880.0);
        gen_case(8'h01, 4'hC, 230400.0);
        gen_case(8'h80, 4'hC, 19200.0);
        gen_case(8'h85, 4'h0, 7200.0);
        $display("end test generator");
        wrap_up;
    end
endmodule // test_duart_baud_clock_select
